// ---- logic/memory_mapped_cache_access.sv ----
// cpu access path to the cache tag and data arrays, with write-back
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
module memory_mapped_cache_access
  import mmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  // cpu register-style port; the only requester
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [DATA_W-1:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [DATA_W-1:0] cpu_rdata_o,
  output logic busy_o,
  // cache array port, asynchronous read
  output logic arr_operand_o,
  output logic [IDX_W-1:0] arr_index_o,
  output logic [1:0] arr_way_o,
  output logic [1:0] arr_word_o,
  input wire tag_entry_t [3:0] tag_rdata_i,
  input wire logic [LRU_W-1:0] lru_rdata_i,
  output logic tag_wr_o,
  output tag_entry_t tag_wdata_o,
  output logic lru_wr_o,
  output logic [LRU_W-1:0] lru_wdata_o,
  input wire logic [DATA_W-1:0] data_rdata_i,
  output logic data_wr_o,
  output logic [DATA_W-1:0] data_wdata_o,
  // write-back path toward the bus controller
  output logic wb_valid_o,
  output logic [ADDR_W-1:0] wb_addr_o,
  output logic [DATA_W-1:0] wb_data_o,
  input wire logic wb_ready_i
);
  typedef struct packed {
    mmc_state_t state;
    logic operand;
    logic [IDX_W-1:0] index;
    logic [1:0] way;
    logic assoc;
    logic [DATA_W-1:0] new_word;
    logic [TAG_W-1:0] old_tag;
    logic [1:0] word;
    logic wb_valid;
    logic [ADDR_W-1:0] wb_addr;
    logic [DATA_W-1:0] wb_data;
    logic [DATA_W-1:0] rdata;
  } mmc_regs_t;

  mmc_regs_t cur;
  mmc_regs_t next_cur;

  logic dec_tag;
  logic dec_data;
  logic dec_operand;
  logic [IDX_W-1:0] dec_index;
  logic [1:0] dec_way;
  logic [1:0] dec_word;
  logic dec_assoc;

  mmc_addr_decode u_decode (
    .addr_i(cpu_addr_i),
    .tag_region_o(dec_tag),
    .data_region_o(dec_data),
    .operand_o(dec_operand),
    .index_o(dec_index),
    .way_o(dec_way),
    .word_o(dec_word),
    .assoc_o(dec_assoc)
  );

  // a hit needs the stored tag equal and the entry valid
  function automatic logic tag_hit(input tag_entry_t e,
                                   input logic [TAG_W-1:0] t);
    tag_hit = e.valid && (e.tag == t);
  endfunction : tag_hit

  // read view of one tag entry; reserved bits read as zero
  function automatic logic [DATA_W-1:0] tag_word(input tag_entry_t e,
      input logic [LRU_W-1:0] lru, input logic operand);
    logic [DATA_W-1:0] w;
    w = '0;
    w[TAG_MSB:TAG_LSB] = e.tag;
    w[LRU_MSB:LRU_LSB] = lru;
    w[DIRTY_BIT] = operand & e.dirty;
    w[VALID_BIT] = e.valid;
    tag_word = w;
  endfunction : tag_word

  // the write-back address is rebuilt from the old tag and the entry
  function automatic logic [ADDR_W-1:0] line_addr(
      input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] idx,
      input logic [1:0] word);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[TAG_MSB:TAG_LSB] = t;
    a[IDX_MSB:IDX_LSB] = idx;
    a[WORD_MSB:WORD_LSB] = word;
    line_addr = a;
  endfunction : line_addr

  // new flags from a tag write; the instruction cache keeps no dirty bit
  function automatic tag_entry_t new_entry(input logic [TAG_W-1:0] t,
      input logic [DATA_W-1:0] w, input logic operand);
    tag_entry_t e;
    e.tag = t;
    e.dirty = operand & w[DIRTY_BIT];
    e.valid = w[VALID_BIT];
    new_entry = e;
  endfunction : new_entry

  logic [3:0] hit_vec;
  logic [1:0] hit_way;
  tag_entry_t sel_entry;
  tag_entry_t hit_entry;
  logic [TAG_W-1:0] wr_tag;

  always_comb begin
    wr_tag = cpu_wdata_i[TAG_MSB:TAG_LSB];
    hit_way = 2'h0;
    for (int i = 0; i < 4; i++) begin
      hit_vec[i] = tag_hit(tag_rdata_i[i], wr_tag);
    end
    // one-hot by contract, so the lowest hit is the only hit
    for (int i = 3; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_way = 2'(i);
      end
    end
    sel_entry = tag_rdata_i[dec_way];
    hit_entry = tag_rdata_i[hit_way];
  end

  always_comb begin
    next_cur = cur;
    next_cur.rdata = '0;
    arr_operand_o = dec_operand;
    arr_index_o = dec_index;
    arr_way_o = dec_way;
    arr_word_o = dec_word;
    tag_wr_o = 1'b0;
    tag_wdata_o = '0;
    lru_wr_o = 1'b0;
    lru_wdata_o = '0;
    data_wr_o = 1'b0;
    data_wdata_o = '0;
    case (cur.state)
      ST_IDLE: begin
        // reads never compare and never write anything
        if (cpu_rd_i && dec_tag) begin
          next_cur.rdata = tag_word(sel_entry, lru_rdata_i, dec_operand);
        end else if (cpu_rd_i && dec_data) begin
          next_cur.rdata = data_rdata_i;
        end
        if (cpu_wr_i && dec_data) begin
          data_wr_o = 1'b1;
          data_wdata_o = cpu_wdata_i;
        end else if (cpu_wr_i && dec_tag) begin
          next_cur.operand = dec_operand;
          next_cur.index = dec_index;
          next_cur.assoc = dec_assoc;
          next_cur.new_word = cpu_wdata_i;
          next_cur.word = FIRST_WORD;
          if (!dec_assoc) begin
            next_cur.way = dec_way;
            next_cur.old_tag = sel_entry.tag;
            if (dec_operand && sel_entry.dirty && sel_entry.valid) begin
              next_cur.state = ST_WB_READ;
            end else begin
              tag_wr_o = 1'b1;
              tag_wdata_o = new_entry(wr_tag, cpu_wdata_i, dec_operand);
              lru_wr_o = 1'b1;
              lru_wdata_o = cpu_wdata_i[LRU_MSB:LRU_LSB];
            end
          end else if (|hit_vec) begin
            arr_way_o = hit_way;
            next_cur.way = hit_way;
            next_cur.old_tag = hit_entry.tag;
            if (dec_operand && hit_entry.dirty) begin
              next_cur.state = ST_WB_READ;
            end else begin
              // tag and LRU stay as they are
              tag_wr_o = 1'b1;
              tag_wdata_o = new_entry(hit_entry.tag, cpu_wdata_i,
                                      dec_operand);
            end
          end
          // an associative miss falls through untouched
        end
      end
      ST_WB_READ: begin
        arr_operand_o = cur.operand;
        arr_index_o = cur.index;
        arr_way_o = cur.way;
        arr_word_o = cur.word;
        next_cur.wb_data = data_rdata_i;
        next_cur.wb_addr = line_addr(cur.old_tag, cur.index, cur.word);
        next_cur.wb_valid = 1'b1;
        next_cur.state = ST_WB_SEND;
      end
      ST_WB_SEND: begin
        arr_operand_o = cur.operand;
        arr_index_o = cur.index;
        arr_way_o = cur.way;
        arr_word_o = cur.word;
        if (wb_ready_i) begin
          next_cur.wb_valid = 1'b0;
          // fixed order 0, 4, 8, C rather than wrapping
          if (cur.word == LAST_WORD) begin
            next_cur.state = ST_UPDATE;
          end else begin
            next_cur.word = cur.word + 2'h1;
            next_cur.state = ST_WB_READ;
          end
        end
      end
      ST_UPDATE: begin
        // tag fields land only after the whole line has left
        arr_operand_o = cur.operand;
        arr_index_o = cur.index;
        arr_way_o = cur.way;
        tag_wr_o = 1'b1;
        if (cur.assoc) begin
          tag_wdata_o = new_entry(cur.old_tag, cur.new_word, cur.operand);
        end else begin
          tag_wdata_o = new_entry(cur.new_word[TAG_MSB:TAG_LSB],
                                  cur.new_word, cur.operand);
          lru_wr_o = 1'b1;
          lru_wdata_o = cur.new_word[LRU_MSB:LRU_LSB];
        end
        next_cur.state = ST_IDLE;
      end
      default: begin
        next_cur.state = ST_IDLE;
        next_cur.wb_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur <= '{state: ST_IDLE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // requests are ignored while busy; the cpu holds off
  assign busy_o = (cur.state != ST_IDLE);
  assign cpu_rdata_o = cur.rdata;
  assign wb_valid_o = cur.wb_valid;
  assign wb_addr_o = cur.wb_addr;
  assign wb_data_o = cur.wb_data;
endmodule : memory_mapped_cache_access

// ---- logic/mmc_addr_decode.sv ----
// address decoder for the mapped cache regions
`timescale 1ns/1ns
module mmc_addr_decode
  import mmc_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  output logic tag_region_o,
  output logic data_region_o,
  output logic operand_o,
  output logic [IDX_W-1:0] index_o,
  output logic [1:0] way_o,
  output logic [1:0] word_o,
  output logic assoc_o
);
  logic [8:0] region;

  assign region = addr_i[REGION_MSB:REGION_LSB];
  assign tag_region_o = (region == REGION_IC_TAG) ||
                        (region == REGION_OC_TAG);
  assign data_region_o = (region == REGION_IC_DATA) ||
                         (region == REGION_OC_DATA);
  assign operand_o = (region == REGION_OC_TAG) ||
                     (region == REGION_OC_DATA);
  assign index_o = addr_i[IDX_MSB:IDX_LSB];
  assign way_o = addr_i[WAY_MSB:WAY_LSB];
  assign word_o = addr_i[WORD_MSB:WORD_LSB];
  assign assoc_o = addr_i[ASSOC_BIT];
endmodule : mmc_addr_decode

// ---- logic/mmc_pkg.sv ----
// constants and types for the memory-mapped cache access block
//
// Notes on behaviour
// - instruction cache tag array F0000000-F07FFFFF, data array F1000000-F17FFFFF.
// - operand cache tag array F0800000-F0FFFFFF, data array F1800000-F1FFFFFF.
// - way-select field 00..11 picks way 0..3 for tag and data access.
// - tag read returns addressed entry fields, never compares, whatever the A bit.
// - non-associative tag write stores tag, LRU, valid (and dirty, operand cache only) into addressed way.
// - operand tag write over a dirty valid line writes the line back first.
// - write-back sends the line's longwords at offsets 0, 4, 8, C in order.
// - associative write compares all four ways; hit updates only dirty and valid.
// - associative write with no hit changes nothing.
// - associative operand write hitting a dirty way writes the line back first.
// - longword-select field 00..11 picks longword 0..3 of the 16-byte line.
// - data array accesses never touch tag, LRU, dirty or valid.
// - data read returns the selected longword of the addressed entry and way.
// - data write stores 32-bit write data at the selected longword.
// - only the cpu reaches these arrays; the dma_controller has no path.
// - entry index comes from address bits 10 to 4.
// - tag match compares write-data bits 31-11 and needs valid set.
package mmc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TAG_W = 21;
  localparam int IDX_W = 7;
  localparam int LRU_W = 6;
  // address bits 31:23 select the region
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 23;
  localparam logic [8:0] REGION_IC_TAG = 9'h1E0;
  localparam logic [8:0] REGION_OC_TAG = 9'h1E1;
  localparam logic [8:0] REGION_IC_DATA = 9'h1E2;
  localparam logic [8:0] REGION_OC_DATA = 9'h1E3;
  localparam int IDX_MSB = 10;
  localparam int IDX_LSB = 4;
  localparam int WAY_MSB = 12;
  localparam int WAY_LSB = 11;
  localparam int WORD_MSB = 3;
  localparam int WORD_LSB = 2;
  localparam int ASSOC_BIT = 3;
  // tag word layout
  localparam int TAG_MSB = 31;
  localparam int TAG_LSB = 11;
  localparam int LRU_MSB = 9;
  localparam int LRU_LSB = 4;
  localparam int DIRTY_BIT = 1;
  localparam int VALID_BIT = 0;
  localparam logic [1:0] LAST_WORD = 2'h3;
  localparam logic [1:0] FIRST_WORD = 2'h0;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic dirty;
    logic valid;
  } tag_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WB_READ = 3'h1,
    ST_WB_SEND = 3'h3,
    ST_UPDATE = 3'h2
  } mmc_state_t;
endpackage : mmc_pkg

// ---- tb/cache_array_model.sv ----
// tag, lru and data arrays plus a write-back sink that may stall
`timescale 1ns/1ns
module cache_array_model
  import mmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic op_i,
  input wire logic [IDX_W-1:0] idx_i,
  input wire logic [1:0] way_i,
  input wire logic [1:0] word_i,
  output tag_entry_t [3:0] tag_o,
  output logic [LRU_W-1:0] lru_o,
  output logic [DATA_W-1:0] data_o,
  input wire logic tag_wr_i,
  input wire tag_entry_t tag_i,
  input wire logic lru_wr_i,
  input wire logic [LRU_W-1:0] lru_i,
  input wire logic data_wr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic ready_o
);
  tag_entry_t tags [2][128][4];
  logic [LRU_W-1:0] lrus [2][128];
  logic [DATA_W-1:0] mem [2][4][128][4];
  logic tick = 1'b0;
  initial begin
    foreach (tags[c, i, w]) tags[c][i][w] = '0;
    foreach (lrus[c, i]) lrus[c][i] = '0;
    foreach (mem[c, w, i, l]) mem[c][w][i][l] = '0;
  end
  always_comb begin
    for (int w = 0; w < 4; w++) tag_o[w] = tags[op_i][idx_i][w];
  end
  assign lru_o = lrus[op_i][idx_i];
  assign data_o = mem[op_i][way_i][idx_i][word_i];
  // a slow sink takes every other beat so the block must hold its offer
  assign ready_o = !slow_i || tick;
  always @(posedge clk_i) begin
    tick <= !tick;
    if (tag_wr_i) tags[op_i][idx_i][way_i] <= tag_i;
    if (lru_wr_i) lrus[op_i][idx_i] <= lru_i;
    if (data_wr_i) mem[op_i][way_i][idx_i][word_i] <= data_i;
  end
endmodule : cache_array_model

// ---- tb/memory_mapped_cache_access_tb.sv ----
// self-checking bench for the memory-mapped cache access block
`timescale 1ns/1ns
module memory_mapped_cache_access_tb;
  import mmc_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cpu_wr_i = 1'b0;
  logic cpu_rd_i = 1'b0;
  logic slow = 1'b0;
  logic [31:0] cpu_addr_i = '0;
  logic [31:0] cpu_wdata_i = '0;
  logic [31:0] cpu_rdata_o, data_rdata_i, data_wdata_o, wb_addr_o, wb_data_o;
  logic busy_o, arr_operand_o, tag_wr_o, lru_wr_o, data_wr_o;
  logic wb_valid_o, wb_ready_i;
  logic [IDX_W-1:0] arr_index_o;
  logic [1:0] arr_way_o, arr_word_o;
  logic [LRU_W-1:0] lru_rdata_i, lru_wdata_o;
  tag_entry_t [3:0] tag_rdata_i;
  tag_entry_t tag_wdata_o;
  logic [63:0] wb_q[$];
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  memory_mapped_cache_access dut (.clk_i, .rstn_i, .cpu_addr_i, .cpu_wdata_i,
    .cpu_wr_i, .cpu_rd_i, .cpu_rdata_o, .busy_o, .arr_operand_o, .arr_index_o,
    .arr_way_o, .arr_word_o, .tag_rdata_i, .lru_rdata_i, .tag_wr_o,
    .tag_wdata_o, .lru_wr_o, .lru_wdata_o, .data_rdata_i, .data_wr_o,
    .data_wdata_o, .wb_valid_o, .wb_addr_o, .wb_data_o, .wb_ready_i);
  cache_array_model arr (.clk_i, .slow_i(slow), .op_i(arr_operand_o),
    .idx_i(arr_index_o), .way_i(arr_way_o), .word_i(arr_word_o),
    .tag_o(tag_rdata_i), .lru_o(lru_rdata_i), .data_o(data_rdata_i),
    .tag_wr_i(tag_wr_o), .tag_i(tag_wdata_o), .lru_wr_i(lru_wr_o),
    .lru_i(lru_wdata_o), .data_wr_i(data_wr_o), .data_i(data_wdata_o),
    .ready_o(wb_ready_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wb_valid_o && wb_ready_i) wb_q.push_back({wb_addr_o, wb_data_o});
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] adr(logic [8:0] r, logic [1:0] w,
      logic [6:0] i, logic [1:0] lo);
    return {r, 10'h0, w, i, lo, 2'h0};
  endfunction : adr
  function automatic logic [31:0] tw(logic [20:0] t, logic [5:0] l,
      logic d, logic v);
    return {t, 1'b0, l, 2'h0, d, v};
  endfunction : tw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // whole-longword data accesses only, never a fetch
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge clk_i);
    cpu_wr_i <= 1'b0;
    #1;
    for (int n = 0; n < 40 && busy_o !== 1'b0; n++) @(posedge clk_i) #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    @(posedge clk_i);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge clk_i);
    cpu_rd_i <= 1'b0;
    #1;
    r = cpu_rdata_o;
  endtask : rd
  task automatic fill(input logic [1:0] w, input logic [6:0] i,
      input logic [31:0] b);
    for (int l = 0; l < 4; l++) wr(adr(REGION_OC_DATA, w, i, l[1:0]), b + l);
  endtask : fill
  task automatic wbchk(input logic [20:0] t, input logic [6:0] i,
      input logic [31:0] b);
    chk(wb_q.size(), 4);
    for (int l = 0; l < 4 && l < wb_q.size(); l++) begin
      chk(wb_q[l][63:32], {t, i, l[1:0], 2'h0});
      chk(wb_q[l][31:0], b + l);
    end
    wb_q.delete();
  endtask : wbchk
  task automatic t_data();
    logic [31:0] r;
    fill(2'h2, 7'h05, 32'hA5000000);
    for (int l = 0; l < 4; l++) wr(adr(REGION_IC_DATA, 2'h2, 7'h05, l[1:0]), l);
    for (int l = 0; l < 4; l++) begin
      rd(adr(REGION_OC_DATA, 2'h2, 7'h05, l[1:0]), r);
      chk(r, 32'hA5000000 + l);
      rd(adr(REGION_IC_DATA, 2'h2, 7'h05, l[1:0]), r);
      chk(r, l);
    end
    $display("data array test done");
  endtask : t_data
  task automatic t_tag();
    logic [31:0] r;
    fill(2'h1, 7'h09, 32'hB0000000);
    wr(adr(REGION_OC_TAG, 2'h1, 7'h09, 2'h0), tw(21'h012345, 6'h2A, 1, 1));
    rd(adr(REGION_OC_TAG, 2'h1, 7'h09, 2'h2), r);
    chk(r, tw(21'h012345, 6'h2A, 1, 1));
    slow <= 1'b1;
    wr(adr(REGION_OC_TAG, 2'h1, 7'h09, 2'h0), tw(21'h00ABCD, 6'h07, 0, 1));
    slow <= 1'b0;
    wbchk(21'h012345, 7'h09, 32'hB0000000);
    rd(adr(REGION_OC_TAG, 2'h1, 7'h09, 2'h0), r);
    chk(r, tw(21'h00ABCD, 6'h07, 0, 1));
    $display("tag write test done");
  endtask : t_tag
  task automatic t_assoc();
    logic [31:0] r;
    // only way 3 of this entry is valid, so no double hit
    fill(2'h3, 7'h14, 32'hC0000000);
    wr(adr(REGION_OC_TAG, 2'h3, 7'h14, 2'h0), tw(21'h000777, 6'h11, 1, 1));
    // tag 000778 matches no way, so this write misses and changes nothing
    wr(adr(REGION_OC_TAG, 2'h0, 7'h14, 2'h2), tw(21'h000778, 6'h3F, 0, 0));
    chk(wb_q.size(), 0);
    rd(adr(REGION_OC_TAG, 2'h3, 7'h14, 2'h0), r);
    chk(r, tw(21'h000777, 6'h11, 1, 1));
    wr(adr(REGION_OC_TAG, 2'h0, 7'h14, 2'h2), tw(21'h000777, 6'h3F, 0, 0));
    wbchk(21'h000777, 7'h14, 32'hC0000000);
    rd(adr(REGION_OC_TAG, 2'h3, 7'h14, 2'h0), r);
    chk(r, tw(21'h000777, 6'h11, 0, 0));
    $display("associative test done");
  endtask : t_assoc
  task automatic t_misc();
    logic [31:0] r;
    rd(32'h20000010, r);
    chk(r, 32'h0);
    wr(32'h20000010, 32'hFFFFFFFF);
    wr(adr(REGION_OC_DATA, 2'h1, 7'h09, 2'h0), 32'h12345678);
    rd(adr(REGION_OC_TAG, 2'h1, 7'h09, 2'h0), r);
    chk(r, tw(21'h00ABCD, 6'h07, 0, 1));
    wr(adr(REGION_IC_TAG, 2'h0, 7'h03, 2'h0), tw(21'h000001, 6'h05, 1, 1));
    rd(adr(REGION_IC_TAG, 2'h0, 7'h03, 2'h0), r);
    chk(r, tw(21'h000001, 6'h05, 0, 1));
    $display("misc test done");
  endtask : t_misc
  task automatic give_verdict();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // the bench plays uncached code: no fetch path touches the arrays
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_data();
    t_tag();
    t_assoc();
    t_misc();
    give_verdict();
  end
endmodule : memory_mapped_cache_access_tb

// ---- tb/mmc_checker_sva.sv ----
// concurrent checks on the cpu and write-back ports of the cache access
`timescale 1ns/1ns
module mmc_checker
  import mmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [DATA_W-1:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [DATA_W-1:0] cpu_rdata_o,
  input wire logic busy_o,
  input wire logic [1:0] arr_word_o,
  input wire logic tag_wr_o,
  input wire logic lru_wr_o,
  input wire logic [DATA_W-1:0] data_rdata_i,
  input wire logic data_wr_o,
  input wire logic [DATA_W-1:0] data_wdata_o,
  input wire logic wb_valid_o,
  input wire logic [ADDR_W-1:0] wb_addr_o,
  input wire logic wb_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic go;
  logic dat;
  logic tg;
  assign go = !busy_o;
  assign dat = cpu_addr_i[31:24] == 8'hF1;
  assign tg = cpu_addr_i[31:24] == 8'hF0;
  chk_rd_idle: assert property (!$past(cpu_rd_i) |-> cpu_rdata_o == '0)
    else $error("read data not zero outside read slot");
  chk_rd_data: assert property (cpu_rd_i && go && dat
    |=> cpu_rdata_o == $past(data_rdata_i))
    else $error("data read value wrong");
  chk_data_write: assert property (cpu_wr_i && go && dat
    |-> data_wr_o && data_wdata_o == cpu_wdata_i
    && arr_word_o == cpu_addr_i[3:2] && !tag_wr_o && !lru_wr_o)
    else $error("data write strobe or word wrong");
  chk_assoc_lru: assert property (cpu_wr_i && go && tg && cpu_addr_i[3]
    |-> !lru_wr_o [*8])
    else $error("associative write touched lru");
  chk_unmapped_quiet: assert property (cpu_wr_i && go && !tg && !dat
    |-> !tag_wr_o && !data_wr_o ##1 !busy_o)
    else $error("unmapped write had effect");
  chk_ic_no_wb: assert property (cpu_wr_i && go && !cpu_addr_i[3]
    && cpu_addr_i[31:23] == REGION_IC_TAG |-> tag_wr_o ##1 !busy_o)
    else $error("instruction tag write not immediate");
  chk_wb_hold: assert property (wb_valid_o && !wb_ready_i
    |=> wb_valid_o && $stable(wb_addr_o))
    else $error("write-back beat dropped before acceptance");
  chk_wb_step: assert property (wb_valid_o && wb_ready_i
    && wb_addr_o[3:2] != 2'h3 |=> !wb_valid_o ##1 wb_valid_o
    && wb_addr_o == $past(wb_addr_o, 2) + 32'h4)
    else $error("write-back word order wrong");
  chk_wb_busy: assert property (wb_valid_o |-> busy_o)
    else $error("write-back without busy");
endmodule : mmc_checker

bind memory_mapped_cache_access mmc_checker chk (.clk_i, .rstn_i,
  .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i, .cpu_rdata_o, .busy_o,
  .arr_word_o, .tag_wr_o, .lru_wr_o, .data_rdata_i, .data_wr_o,
  .data_wdata_o, .wb_valid_o, .wb_addr_o, .wb_ready_i);
